//--- logic/rsc_pkg.sv
`default_nettype none

package rsc_pkg;
	localparam logic [3:0]  OFF_CMD        = 4'h0;
	localparam logic [3:0]  OFF_STATUS     = 4'h4;
	localparam logic [3:0]  OFF_CONFIG     = 4'h8;
	localparam logic [7:0]  RST_KEY        = 8'hA5;
	localparam int          KEY_LSB        = 24;
	localparam int          CMD_CPU_BIT    = 0;
	localparam int          CMD_PER_BIT    = 2;
	localparam int          CMD_PIN_BIT    = 3;
	localparam int          ST_FALL_BIT    = 0;
	localparam int          ST_CAUSE_LSB   = 8;
	localparam int          ST_LEVEL_BIT   = 16;
	localparam int          ST_BUSY_BIT    = 17;
	localparam int          CFG_EXP_LSB    = 8;
	localparam logic [1:0]  STARTUP_TICKS  = 2'h3;
	localparam logic [1:0]  SYNC_TICKS     = 2'h2;
	localparam logic [2:0]  CAUSE_GENERAL  = 3'h0;
	localparam logic [2:0]  CAUSE_WAKE     = 3'h1;
	localparam logic [2:0]  CAUSE_WDOG     = 3'h2;
	localparam logic [2:0]  CAUSE_SOFT     = 3'h3;
	localparam logic [2:0]  CAUSE_USER     = 3'h4;
	localparam logic        FALL_RESET     = 1'h0;
	localparam logic        FALL_MAIN_PWR  = 1'h1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAKE_HOLD,
		ST_WAKE_START,
		ST_USER_LOW,
		ST_USER_SYNC,
		ST_USER_START,
		ST_WDOG,
		ST_SOFT
	} rsc_state_type;
endpackage

`default_nettype wire

//--- logic/rsc_pin_if.sv
`timescale 1ns/10ps
`default_nettype none

interface rsc_pin_if #(
	parameter int EXP_W = 4
);
	logic             start;
	logic [EXP_W-1:0] exponent;
	logic             busy;

	modport ctrl (output start, output exponent, input busy);
	modport shaper (input start, input exponent, output busy);
endinterface

`default_nettype wire

//--- logic/rsc_pin_shaper.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_pin_shaper
	import rsc_pkg::*;
#(
	parameter int EXP_W = 4
) (
	input  wire logic  sys_clk,
	input  wire logic  nrst,
	input  wire logic  clkEn,
	input  wire logic  slowTick,
	rsc_pin_if.shaper  port
);
	localparam int CNT_W = (1 << EXP_W) + 2;

	logic [CNT_W-1:0] remain;

	assign port.busy = remain != '0;

	// A new start reloads the full length, so overlapping requests
	// at an unchanged exponent never shorten a pulse already on the pin
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			remain <= '0;
		end else if (clkEn) begin
			if (port.start) begin
				// Widened first so the largest exponent cannot wrap to zero
				remain <= CNT_W'(1) << ({1'b0, port.exponent}
					+ (EXP_W+1)'(1));
			end else if (slowTick && port.busy) begin
				remain <= remain - CNT_W'(1);
			end
		end
	end

	property p_load;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && port.start |=> port.busy;
	endproperty
	a_load: assert property (p_load) else $error("pulse not started");
endmodule // rsc_pin_shaper

`default_nettype wire

//--- logic/rsc_reset_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_ctrl
	import rsc_pkg::*;
#(
	parameter int EXP_W = 4
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	input  wire logic        slowTick,
	input  wire logic        mainPorActive,
	input  wire logic        wdFault,
	input  wire logic        wdCpuOnly,
	input  wire logic        wdResetEnable,
	input  wire logic        pinIn,
	output logic             pinOut,
	output logic             pinDriveEnN,
	output logic             procNrst,
	output logic             periphNrst,
	output logic             cpuClkEn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [3:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata
);
	generate
		if (EXP_W < 1 || EXP_W > 5) begin : g_bad_width
			$error("EXP_W must be 1 to 5");
		end
	endgenerate

	rsc_state_type    state;
	rsc_state_type    next_state;
	logic [1:0]       tickCnt;
	logic [1:0]       tickLimit;
	logic [2:0]       lastCause;
	logic [EXP_W-1:0] pulseExp;
	logic             pinLevel;
	logic             pinFallSeen;
	logic             ownDrive;
	logic             wdPartial;
	logic             cmdCpu;
	logic             cmdPer;
	logic             wrAccess;
	logic             rdSetup;
	logic             rdAccess;
	logic             keyOk;
	logic             cmdAny;
	logic             cmdTake;
	logic             userReq;
	logic             wdReq;
	logic             tickDone;
	logic             entering;
	logic             ownStart;
	logic             pinHold;
	logic             next_wdPartial;
	logic             next_cmdCpu;
	logic             next_cmdPer;
	logic             next_procNrst;
	logic             next_periphNrst;
	logic             next_cpuClkEn;
	logic [31:0]      statusWord;
	logic [31:0]      readWord;

	rsc_pin_if #(.EXP_W(EXP_W)) pinIf ();

	rsc_pin_shaper #(.EXP_W(EXP_W)) u_shaper (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.clkEn    (clkEn),
		.slowTick (slowTick),
		.port     (pinIf.shaper)
	);

	assign wrAccess = psel & penable & pwrite;
	assign rdSetup  = psel & ~penable & ~pwrite;
	assign rdAccess = psel & penable & ~pwrite;
	assign keyOk    = pwdata[KEY_LSB +: 8] == RST_KEY;
	assign cmdAny   = pwdata[CMD_CPU_BIT] | pwdata[CMD_PER_BIT]
		| pwdata[CMD_PIN_BIT];
	// Only an idle manager takes a command: busy, watchdog and
	// user states all refuse it
	assign cmdTake  = wrAccess && paddr == OFF_CMD && keyOk && cmdAny
		&& state == ST_IDLE;
	// A low pin that this block itself caused is not a user reset
	assign userReq  = ~pinIn & ~ownDrive;
	assign wdReq    = wdFault & wdResetEnable;

	assign tickLimit = (state == ST_USER_SYNC) ? SYNC_TICKS : STARTUP_TICKS;
	assign tickDone  = slowTick && tickCnt == tickLimit - 2'h1;

	always_comb begin
		next_state = state;
		if (mainPorActive) begin
			next_state = ST_WAKE_HOLD;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (userReq) begin
						next_state = ST_USER_LOW;
					end else if (wdReq) begin
						next_state = ST_WDOG;
					end else if (cmdTake) begin
						next_state = ST_SOFT;
					end
				end
				ST_WAKE_HOLD: begin
					if (slowTick) begin
						next_state = ST_WAKE_START;
					end
				end
				ST_WAKE_START: begin
					if (tickDone) begin
						next_state = ST_IDLE;
					end
				end
				ST_USER_LOW: begin
					if (pinIn) begin
						next_state = ST_USER_SYNC;
					end
				end
				ST_USER_SYNC: begin
					if (!pinIn) begin
						next_state = ST_USER_LOW;
					end else if (tickDone) begin
						next_state = ST_USER_START;
					end
				end
				ST_USER_START: begin
					if (userReq) begin
						next_state = ST_USER_LOW;
					end else if (tickDone) begin
						next_state = ST_IDLE;
					end
				end
				ST_WDOG: begin
					if (tickDone) begin
						next_state = ST_IDLE;
					end
				end
				ST_SOFT: begin
					if (wdReq) begin
						next_state = ST_WDOG;
					end else if (tickDone) begin
						next_state = ST_IDLE;
					end
				end
			endcase
		end
	end

	assign entering = next_state != state;
	assign pinHold  = next_state == ST_WAKE_HOLD
		|| next_state == ST_WAKE_START;

	assign next_wdPartial = (state == ST_WDOG) ? wdPartial : wdCpuOnly;
	assign next_cmdCpu = (state == ST_SOFT) ? cmdCpu : pwdata[CMD_CPU_BIT];
	assign next_cmdPer = (state == ST_SOFT) ? cmdPer : pwdata[CMD_PER_BIT];

	// Pulses that this block starts on its own behalf
	assign ownStart = entering && ((next_state == ST_SOFT
		&& pwdata[CMD_PIN_BIT]) || (next_state == ST_WDOG
		&& !wdCpuOnly));

	// User entry also starts a pulse so the pin is low for the
	// full length; the user state then lasts until the pin rises
	assign pinIf.start = ownStart || (state == ST_WAKE_START
		&& next_state == ST_IDLE) || (entering
		&& next_state == ST_USER_LOW && state != ST_USER_SYNC);
	assign pinIf.exponent = pulseExp;

	always_comb begin
		next_procNrst   = 1'b1;
		next_periphNrst = 1'b1;
		next_cpuClkEn   = 1'b1;
		unique case (next_state)
			ST_IDLE: begin
			end
			ST_WAKE_HOLD, ST_USER_LOW, ST_USER_SYNC: begin
				next_procNrst   = 1'b0;
				next_periphNrst = 1'b0;
				next_cpuClkEn   = 1'b0;
			end
			ST_WAKE_START, ST_USER_START: begin
				next_procNrst   = 1'b0;
				next_periphNrst = 1'b0;
			end
			ST_WDOG: begin
				next_procNrst   = 1'b0;
				next_periphNrst = next_wdPartial;
			end
			ST_SOFT: begin
				next_procNrst   = ~next_cmdCpu;
				next_periphNrst = ~next_cmdPer;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else if (clkEn) begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt <= 2'h0;
		end else if (clkEn) begin
			if (entering) begin
				tickCnt <= 2'h0;
			end else if (slowTick) begin
				tickCnt <= tickCnt + 2'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wdPartial <= 1'b0;
			cmdCpu    <= 1'b0;
			cmdPer    <= 1'b0;
		end else if (clkEn) begin
			wdPartial <= next_wdPartial;
			cmdCpu    <= next_cmdCpu;
			cmdPer    <= next_cmdPer;
		end
	end

	// Held until the pin is seen high again after our pulse, since
	// the line rises slowly once released
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ownDrive <= 1'b1; // Pin is driven low while in reset
		end else if (clkEn) begin
			if (ownStart || pinHold) begin
				ownDrive <= 1'b1;
			end else if (!pinIf.busy && pinIn) begin
				ownDrive <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			procNrst    <= 1'b0;
			periphNrst  <= 1'b0;
			cpuClkEn    <= 1'b0;
			pinDriveEnN <= 1'b0;
			pinOut      <= 1'b0;
		end else if (clkEn) begin
			procNrst    <= next_procNrst;
			periphNrst  <= next_periphNrst;
			cpuClkEn    <= next_cpuClkEn;
			// Start is included so the wake hold runs into the pulse
			// with no released cycle between them
			pinDriveEnN <= ~(pinIf.busy | pinIf.start | pinHold);
			pinOut      <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			lastCause <= CAUSE_GENERAL;
		end else if (clkEn && next_state == ST_IDLE) begin
			unique case (state)
				ST_WAKE_START: lastCause <= CAUSE_WAKE;
				ST_USER_START: lastCause <= CAUSE_USER;
				ST_WDOG:       lastCause <= CAUSE_WDOG;
				ST_SOFT: begin
					if (cmdCpu) begin
						lastCause <= CAUSE_SOFT;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinLevel <= 1'b0;
		end else if (clkEn) begin
			pinLevel <= pinIn;
		end
	end

	// A fall in the same cycle as the clearing read still sets
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinFallSeen <= FALL_RESET;
		end else if (clkEn) begin
			if (mainPorActive) begin
				pinFallSeen <= FALL_MAIN_PWR;
			end else if (pinLevel && !pinIn) begin
				pinFallSeen <= 1'b1;
			end else if (rdAccess && paddr == OFF_STATUS) begin
				pinFallSeen <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pulseExp <= '0;
		end else if (clkEn && wrAccess && paddr == OFF_CONFIG && keyOk) begin
			pulseExp <= pwdata[CFG_EXP_LSB +: EXP_W];
		end
	end

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ST_FALL_BIT] = pinFallSeen;
		statusWord[ST_CAUSE_LSB +: 3] = lastCause;
		statusWord[ST_LEVEL_BIT] = pinLevel;
		statusWord[ST_BUSY_BIT] = state == ST_SOFT;
		readWord = 32'h0000_0000;
		if (paddr == OFF_STATUS) begin
			readWord = statusWord;
		end else if (paddr == OFF_CONFIG) begin
			readWord[CFG_EXP_LSB +: EXP_W] = pulseExp;
		end
	end

	// Read data is captured in the setup phase so it leaves a flop
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (clkEn && rdSetup) begin
			prdata <= readWord;
		end
	end

	property p_main_hold;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && mainPorActive |=> !procNrst && !periphNrst && !cpuClkEn;
	endproperty
	a_main_hold: assert property (p_main_hold) else $error("main hold");

	property p_main_prio;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && mainPorActive |=> state == ST_WAKE_HOLD;
	endproperty
	a_main_prio: assert property (p_main_prio) else $error("prio");

	property p_wake_cause;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && state == ST_WAKE_START && next_state == ST_IDLE
		|=> lastCause == CAUSE_WAKE && procNrst && !pinDriveEnN;
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake");

	property p_user_entry;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && state == ST_IDLE && !mainPorActive && !pinIn && !ownDrive
		|=> !procNrst && !periphNrst;
	endproperty
	a_user_entry: assert property (p_user_entry) else $error("user");

	property p_user_cause;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && state == ST_USER_START && next_state == ST_IDLE
		|=> lastCause == CAUSE_USER;
	endproperty
	a_user_cause: assert property (p_user_cause) else $error("cause");

	property p_bad_key;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && state == ST_IDLE && wrAccess && paddr == OFF_CMD
		&& !keyOk |=> state != ST_SOFT;
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("key");

	property p_soft_take;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && cmdTake && !mainPorActive && !userReq && !wdReq
		|=> state == ST_SOFT && procNrst == !$past(pwdata[CMD_CPU_BIT]);
	endproperty
	a_soft_take: assert property (p_soft_take) else $error("soft");

	property p_wd_off;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && state == ST_IDLE && !wdResetEnable && !cmdTake
		&& !userReq && !mainPorActive |=> state == ST_IDLE;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("wd off");

	property p_wd_partial;
		@(posedge sys_clk) disable iff (!nrst)
		state == ST_WDOG && wdPartial |-> periphNrst && !procNrst;
	endproperty
	a_wd_partial: assert property (p_wd_partial) else $error("wd");

	property p_fall;
		@(posedge sys_clk) disable iff (!nrst)
		clkEn && pinLevel && !pinIn |=> pinFallSeen;
	endproperty
	a_fall: assert property (p_fall) else $error("fall");
endmodule // rsc_reset_ctrl

`default_nettype wire

//--- testbench/rsc_pin_partner.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_pin_partner (
	input  wire logic pinOut,
	input  wire logic pinDriveEnN,
	input  wire logic extLow,
	output logic      pinLevel
);
	// Pull-up wire: a released pin reads high unless extLow pulls it low, not its last value
	assign pinLevel = !pinDriveEnN ? pinOut : !extLow;
endmodule // rsc_pin_partner

`default_nettype wire

//--- testbench/system_reset_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none

module system_reset_controller_bench;
	import rsc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        slowTick = 1'b0;
	logic        clkEn = 1'b1;
	logic        nrst, mainPorActive, wdFault;
	logic        wdCpuOnly, wdResetEnable, extLow, pinIn;
	logic        pinOut, pinDriveEnN, procNrst, periphNrst, cpuClkEn;
	logic        psel, penable, pwrite;
	logic [3:0]  paddr;
	logic [2:0]  tickCnt = 3'h0;
	logic [31:0] pwdata, prdata, rd;
	int          failCount = 0;
	int          checkCount = 0;
	int          n;
	// Command, processor reset, peripheral reset, cause afterwards
	logic [36:0] rows [4] = '{
		{32'hA5000004, 1'b1, 1'b0, CAUSE_WAKE},
		{32'h5A000001, 1'b1, 1'b1, CAUSE_WAKE},
		{32'hA5000001, 1'b0, 1'b1, CAUSE_SOFT},
		{32'hA5000005, 1'b0, 1'b0, CAUSE_SOFT}
	};

	always #2 sys_clk = ~sys_clk;

	// Slow clock stands in as one tick every eight cycles
	always @(posedge sys_clk) begin
		tickCnt  <= tickCnt + 3'h1;
		slowTick <= (tickCnt == 3'h7);
	end

	rsc_pin_partner rsc_pin_partner_inst (
		.pinOut      (pinOut),
		.pinDriveEnN (pinDriveEnN),
		.extLow      (extLow),
		.pinLevel    (pinIn)
	);

	rsc_reset_ctrl rsc_reset_ctrl_inst (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.clkEn         (clkEn),
		.slowTick      (slowTick),
		.mainPorActive (mainPorActive),
		.wdFault       (wdFault),
		.wdCpuOnly     (wdCpuOnly),
		.wdResetEnable (wdResetEnable),
		.pinIn         (pinIn),
		.pinOut        (pinOut),
		.pinDriveEnN   (pinDriveEnN),
		.procNrst      (procNrst),
		.periphNrst    (periphNrst),
		.cpuClkEn      (cpuClkEn),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata)
	);

	task automatic finalReport;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic bit_chk(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	task automatic wd_pulse;
		@(posedge sys_clk);
		wdFault <= 1'b1;
		@(posedge sys_clk);
		wdFault <= 1'b0;
	endtask

	// Bounded wait for the processor release
	task automatic wait_rel;
		n = 0;
		while (procNrst !== 1'b1 && n < 600) begin
			@(posedge sys_clk);
			n++;
		end
		bit_chk(n < 600, 1'b1);
		#1;
	endtask

	// Pin low time in cycles, one tick of slack for phase
	task automatic pulse_len(input int e);
		n = 0;
		while (pinDriveEnN !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		while (pinDriveEnN === 1'b0 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		bit_chk(n >= e - 8 && n <= e + 8, 1'b1);
	endtask

	initial begin
		nrst = 1'b0;
		mainPorActive = 1'b0;
		wdFault = 1'b0;
		wdCpuOnly = 1'b0;
		wdResetEnable = 1'b1;
		extLow = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		cyc(3);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h00010000);
		mainPorActive <= 1'b1;
		cyc(3);
		bit_chk(procNrst, 1'b0);
		bit_chk(periphNrst, 1'b0);
		bit_chk(pinDriveEnN, 1'b0);
		bit_chk(cpuClkEn, 1'b0);
		bit_chk(pinOut, 1'b0);
		mainPorActive <= 1'b0;
		wait_rel();
		pulse_len(16);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h00030701, 32'h00010101);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h00030701, 32'h00010100);
		bus(1'b1, OFF_CONFIG, 32'hA5000100);
		bus(1'b1, OFF_CONFIG, 32'h00000300);
		bus(1'b0, OFF_CONFIG, 32'h0);
		chk(rd, 32'h00000100);
		foreach (rows[i]) begin
			bus(1'b1, OFF_CMD, rows[i][36:5]);
			cyc(1);
			bit_chk(procNrst, rows[i][4]);
			bit_chk(periphNrst, rows[i][3]);
			cyc(120);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk(rd & 32'h00020700, {21'h0, rows[i][2:0], 8'h0});
		end
		bus(1'b1, OFF_CMD, 32'hA5000008);
		pulse_len(32);
		cyc(40);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h00000700, 32'h00000300);
		bus(1'b1, OFF_CMD, 32'hA5000001);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h00020000, 32'h00020000);
		bus(1'b1, OFF_CMD, 32'hA5000004);
		cyc(1);
		bit_chk(periphNrst, 1'b1);
		cyc(60);
		wdResetEnable <= 1'b0;
		wd_pulse();
		cyc(3);
		bit_chk(procNrst, 1'b1);
		wdResetEnable <= 1'b1;
		wdCpuOnly <= 1'b1;
		wd_pulse();
		cyc(3);
		bit_chk(procNrst, 1'b0);
		bit_chk(periphNrst, 1'b1);
		cyc(60);
		bus(1'b1, OFF_CMD, 32'hA5000001);
		wdCpuOnly <= 1'b0;
		wd_pulse();
		cyc(3);
		bit_chk(periphNrst, 1'b0);
		pulse_len(32);
		cyc(80);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h00020700, 32'h00000200);
		extLow <= 1'b1;
		cyc(3);
		bit_chk(procNrst, 1'b0);
		bit_chk(periphNrst, 1'b0);
		cyc(100);
		bit_chk(procNrst, 1'b0);
		extLow <= 1'b0;
		cyc(28);
		bit_chk(cpuClkEn, 1'b1);
		bit_chk(procNrst, 1'b0);
		wait_rel();
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h00000701, 32'h00000401);
		// A frozen block must not let a software reset run out
		bus(1'b1, OFF_CMD, 32'hA5000001);
		clkEn <= 1'b0;
		cyc(40);
		bit_chk(procNrst, 1'b0);
		clkEn <= 1'b1;
		wait_rel();
		finalReport();
	end

	initial begin
		#40000;
		failCount++;
		finalReport();
	end
endmodule // system_reset_controller_bench

`default_nettype wire
